// >>> rtl/tsb_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for controller pins
// Assumes: pins are asynchronous to the reference clock
// Notes:   a pin level is accepted once the second and third stages agree
`timescale 1ns/100ps
module tsb_pin_sync #(
    parameter int               WIDTH       = 4,
    parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    import tsb_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } tsb_sync_t;

    tsb_sync_t st;
    tsb_sync_t next_st;

    // stage one feeds stage two only; filter looks at two and three
    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.q  = (st.s3 & ~(st.s2 ^ st.s3)) | (st.q & (st.s2 ^ st.s3)); // [R1] [R2]
    end

    // every stage starts at its pin's idle level, so release makes no false edge
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL, q: RESET_LEVEL}; // [R8]
        end else begin
            st <= next_st;
        end
    end

    assign q = st.q;

    sync_agree_a: assert property (@(posedge clk) disable iff (rst) // [R2]
        1'b1 |=> ((st.q ^ $past(st.q)) & ($past(st.s2) ^ $past(st.s3))) == '0)
        else $error("filtered level moved while stages disagreed");

    sync_idle_high_a: assert property (@(posedge clk) // [R8]
        rst |=> st.q == RESET_LEVEL)
        else $error("filtered level not at idle after reset");

endmodule

// >>> rtl/tsb_pkg.sv
// Purpose: shared constants, types and cell decoders for the test scan port
// Assumes: one 168-cell boundary chain and a two-bit instruction register
// Notes:   cell numbers follow the chain order, cell 0 nearest the serial output
package tsb_pkg;

    // chain and instruction sizes
    localparam int          BSR_LEN     = 168;
    localparam int          IR_LEN      = 2;

    // instruction codes; any code not listed selects the one-bit bypass path
    localparam logic [1:0]  IR_EXTEST   = 2'h0;
    localparam logic [1:0]  IR_SAMPLE   = 2'h1;
    localparam logic [1:0]  IR_BYPASS   = 2'h3;
    localparam logic [1:0]  IR_RESET    = IR_BYPASS;
    localparam logic [1:0]  IR_CAPTURE  = 2'h1;

    // pin groups wrapped by the chain
    localparam int          DATA_BITS   = 16;
    localparam int          STREAMS     = 32;
    localparam int          DATA_TOP_EN = 24;
    localparam int          DATA_CELLS  = 3;
    localparam int          STREAM_BASE = 72;
    localparam int          STREAM_GRP  = 8;
    localparam int          STREAM_STEP = 24;
    localparam int          STREAM_CELLS = 2;
    localparam int          ACK_OUT_CELL = 23;

    // synchroniser depth for pins from the test controller
    localparam int          SYNC_STAGES = 3;

    typedef enum logic [3:0] {
        TAP_TLR, TAP_RTI,
        TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR, TAP_EX2_DR, TAP_UP_DR,
        TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UP_IR
    } tsb_tap_t;

    // pins from the test controller
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tsb_pins_t;

    // values the update latches present to the pad muxes
    typedef struct packed {
        logic                 extest;
        logic [STREAMS-1:0]   stream_oe;
        logic [STREAMS-1:0]   stream_out;
        logic [DATA_BITS-1:0] data_oe;
        logic [DATA_BITS-1:0] data_out;
        logic                 ack_out;
    } tsb_drive_t;

    // enable cell of a host data bit; output and input follow it
    function automatic int data_en_cell(input int bit_n);
        return DATA_TOP_EN + DATA_CELLS * (DATA_BITS - 1 - bit_n);
    endfunction

    // enable cell of a serial output stream; its output cell follows it
    function automatic int stream_en_cell(input int n);
        int k;
        k = STREAMS - 1 - n;
        return STREAM_BASE + STREAM_STEP * (k / STREAM_GRP)
               + STREAM_CELLS * (k % STREAM_GRP);
    endfunction

endpackage

// >>> rtl/tsb_scan_port.sv
// Purpose: boundary-scan test port with bypass and 168-cell boundary chain
// Assumes: test pins are oversampled by the reference clock, several times per test clock
// Notes:   core pads use the drive bundle only while extest is current
`timescale 1ns/100ps

// Operation
// (R1) mode select is taken on each test clock rise and steers the controller
// (R2) test data input is sampled on each test clock rise
// (R3) shifted bits enter instruction or selected data register by controller state
// (R4) test data output changes on each test clock fall
// (R5) test data output is released whenever nothing is being shifted
// (R6) test reset clears the controller and the instruction register
// (R7) test clock is independent; scanning never disturbs the running core
// (R8) undriven mode select, data input and test reset read high
// (R9) instruction register is two bits wide
// (R10) instruction register loads serially only in shift-instruction state
// (R11) instruction picks the data register and serial path for data scans
// (R12) exactly two data registers exist: boundary chain and bypass
// (R13) bypass is a single stage between data input and output
// (R14) boundary chain holds cells 0 through 167 around the core
// (R15) cell 0 is the first bit driven onto the data output
// (R16) every enable cell turns its driver on when it holds one
// (R17) input pins one cell; streams enable then output; data bits enable, output, input
// (R18) controller follows the sixteen-state sequence the test controller walks
module tsb_scan_port #(
    parameter int CELLS = tsb_pkg::BSR_LEN
) (
    input  wire logic                 REF_CLK,
    input  wire logic                 RST,
    input  wire tsb_pkg::tsb_pins_t   PINS,
    input  wire logic [CELLS-1:0]     CORE_CAPTURE,
    output logic                      TDO,
    output logic                      TDO_OE,
    output tsb_pkg::tsb_drive_t       DRIVE
);
    import tsb_pkg::*;

    typedef struct packed {
        logic              tck;
        logic [IR_LEN-1:0] ir_sh;
        logic [IR_LEN-1:0] ir;
        logic              byp;
        logic [CELLS-1:0]  bsr;
        logic [CELLS-1:0]  upd;
        logic              tdo;
        logic              oe;
    } tsb_scan_t;

    // tck reset low matches the parked-low test clock so no false fall at release
    localparam tsb_scan_t SCAN_RESET = '{
        tck:   1'b0,
        ir_sh: IR_CAPTURE,
        ir:    IR_RESET,
        byp:   1'b0,
        bsr:   '0,
        upd:   '0,
        tdo:   1'b0,
        oe:    1'b0
    };

    tsb_scan_t st;
    tsb_scan_t next_st;
    tsb_pins_t pin_q;
    tsb_tap_t  tap;

    logic tck_rise;
    logic tck_fall;
    logic test_rst;
    logic bsr_sel;
    logic extest;
    logic shifting;
    logic serial_bit;

    // controller pins cross into the reference clock domain
    tsb_pin_sync #(
        .WIDTH       (4),
        .RESET_LEVEL (4'h7) // tck parks low; tms, tdi and trst_n idle high [R8]
    ) u_sync (
        .clk (REF_CLK),
        .rst (RST),
        .d   (PINS),
        .q   (pin_q)
    );

    // test clock edges found from the filtered level
    assign tck_rise = pin_q.tck & ~st.tck;
    assign tck_fall = ~pin_q.tck & st.tck;

    // test reset pin acts alongside system reset
    assign test_rst = RST | ~pin_q.trst_n; // [R6]

    tsb_tap_fsm u_tap (
        .clk   (REF_CLK),
        .rst   (test_rst),
        .step  (tck_rise),
        .tms   (pin_q.tms),
        .state (tap)
    );

    // instruction decode: extest and sample use the chain, all else bypass
    assign bsr_sel = (st.ir == IR_EXTEST) || (st.ir == IR_SAMPLE); // [R11] [R12]
    assign extest  = (st.ir == IR_EXTEST);

    // output driven only while a shift state is current
    assign shifting = (tap == TAP_SH_DR) || (tap == TAP_SH_IR);

    // serial path toward the output, chosen by state then instruction
    always_comb begin
        if (tap == TAP_SH_IR) begin
            serial_bit = st.ir_sh[0];
        end else if (bsr_sel) begin
            serial_bit = st.bsr[0]; // [R15]
        end else begin
            serial_bit = st.byp; // [R13]
        end
    end

    // rising-edge work: capture and shift; falling-edge work: output and update
    always_comb begin
        next_st     = st;
        next_st.tck = pin_q.tck;

        if (tck_rise) begin
            if (tap == TAP_CAP_IR) begin
                next_st.ir_sh = IR_CAPTURE;
            end else if (tap == TAP_SH_IR) begin
                next_st.ir_sh = {pin_q.tdi, st.ir_sh[IR_LEN-1:1]}; // [R2] [R3] [R9] [R10]
            end else if (tap == TAP_CAP_DR && bsr_sel) begin
                next_st.bsr = CORE_CAPTURE; // [R14] [R17]
            end else if (tap == TAP_CAP_DR) begin
                next_st.byp = 1'b0;
            end else if (tap == TAP_SH_DR && bsr_sel) begin
                next_st.bsr = {pin_q.tdi, st.bsr[CELLS-1:1]}; // [R3] [R14]
            end else if (tap == TAP_SH_DR) begin
                next_st.byp = pin_q.tdi; // [R3] [R13]
            end
        end

        if (tck_fall) begin
            next_st.tdo = shifting ? serial_bit : 1'b0; // [R4]
            next_st.oe  = shifting; // [R5]
            if (tap == TAP_UP_IR) begin
                next_st.ir = st.ir_sh; // [R11]
            end else if (tap == TAP_UP_DR && bsr_sel) begin
                // latches move only here or on test reset, so the core sees no shifting ripple
                next_st.upd = st.bsr; // [R7]
            end else if (tap == TAP_TLR) begin
                next_st.ir = IR_RESET;
            end
        end

        // test reset keeps edge tracking but clears all scan state
        if (test_rst) begin
            next_st     = SCAN_RESET; // [R6]
            next_st.tck = pin_q.tck;
        end
    end

    // single register for all port state outside the controller and synchroniser
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            st <= SCAN_RESET;
        end else begin
            st <= next_st;
        end
    end

    // serial output pin; the pad resolves high impedance from the enable
    assign TDO    = st.tdo;
    assign TDO_OE = st.oe; // [R5]

    // drive bundle; the core keeps its pads unless extest is current
    assign DRIVE.extest  = extest; // [R7]
    assign DRIVE.ack_out = st.upd[ACK_OUT_CELL];

    // host data bits: enable, output, input cells in order
    for (genvar i = 0; i < DATA_BITS; i++) begin : g_data
        assign DRIVE.data_oe[i]  = st.upd[data_en_cell(i)]; // [R16] [R17]
        assign DRIVE.data_out[i] = st.upd[data_en_cell(i) + 1];
    end

    // serial output streams: enable then output cell
    for (genvar n = 0; n < STREAMS; n++) begin : g_stream
        assign DRIVE.stream_oe[n]  = st.upd[stream_en_cell(n)]; // [R16] [R17]
        assign DRIVE.stream_out[n] = st.upd[stream_en_cell(n) + 1];
    end

    // output moves only on a falling test clock edge or a reset
    tdo_fall_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R4]
        $changed(TDO) |-> $past(tck_fall) || $past(test_rst))
        else $error("test output changed away from a falling edge");

    // a fall outside a shift state releases the output
    tdo_release_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R5]
        tck_fall && !shifting |=> !TDO_OE)
        else $error("test output driven outside a shift state");

    // instruction shift drives its low bit out
    ir_out_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R5]
        tck_fall && tap == TAP_SH_IR && !test_rst
        |=> TDO_OE && TDO == $past(st.ir_sh[0]))
        else $error("instruction bit not driven during shift");

    // cell 0 leaves first on a chain scan
    chain_first_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R15]
        tck_fall && tap == TAP_SH_DR && bsr_sel && !test_rst
        |=> TDO == $past(st.bsr[0]))
        else $error("chain output is not cell 0");

    // bypass takes the input bit on the rise
    bypass_stage_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R13]
        tck_rise && tap == TAP_SH_DR && !bsr_sel && !test_rst
        |=> st.byp == $past(pin_q.tdi))
        else $error("bypass stage missed the input bit");

    // instruction shifter moves only in capture or shift of the instruction
    ir_shift_only_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R10]
        $changed(st.ir_sh)
        |-> $past(tck_rise && (tap == TAP_SH_IR || tap == TAP_CAP_IR)) || $past(test_rst))
        else $error("instruction shifter moved outside its states");

    // update state makes the shifted code current
    ir_update_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R11]
        tck_fall && tap == TAP_UP_IR && !test_rst |=> st.ir == $past(st.ir_sh))
        else $error("instruction not updated from shifter");

    // core-facing latches hold through shifting
    core_quiet_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R7]
        $changed(st.upd)
        |-> $past(tck_fall && tap == TAP_UP_DR && bsr_sel) || $past(test_rst))
        else $error("update latches moved outside update state");

    // test reset pin clears instruction and releases output
    trst_clear_a: assert property (@(posedge REF_CLK) disable iff (RST) // [R6]
        !pin_q.trst_n |=> st.ir == IR_RESET && !TDO_OE)
        else $error("test reset did not clear the port");

endmodule

// >>> rtl/tsb_tap_fsm.sv
// Purpose: sixteen-state test access controller stepped by test clock rises
// Assumes: step is a one-cycle pulse per filtered test clock rising edge
// Notes:   rst covers both system reset and the test reset pin
`timescale 1ns/100ps
module tsb_tap_fsm (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        step,
    input  wire logic        tms,
    output tsb_pkg::tsb_tap_t state
);
    import tsb_pkg::*;

    typedef struct packed {
        tsb_tap_t tap;
    } tsb_ctl_t;

    tsb_ctl_t st;
    tsb_ctl_t next_st;

    // mode select steers the controller only on a test clock rise
    always_comb begin
        next_st = st;
        if (step) begin // [R1]
            unique case (st.tap) // [R18]
                TAP_TLR:    next_st.tap = tms ? TAP_TLR    : TAP_RTI;
                TAP_RTI:    next_st.tap = tms ? TAP_SEL_DR : TAP_RTI;
                TAP_SEL_DR: next_st.tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
                TAP_CAP_DR: next_st.tap = tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_SH_DR:  next_st.tap = tms ? TAP_EX1_DR : TAP_SH_DR;
                TAP_EX1_DR: next_st.tap = tms ? TAP_UP_DR  : TAP_PA_DR;
                TAP_PA_DR:  next_st.tap = tms ? TAP_EX2_DR : TAP_PA_DR;
                TAP_EX2_DR: next_st.tap = tms ? TAP_UP_DR  : TAP_SH_DR;
                TAP_UP_DR:  next_st.tap = tms ? TAP_SEL_DR : TAP_RTI;
                TAP_SEL_IR: next_st.tap = tms ? TAP_TLR    : TAP_CAP_IR;
                TAP_CAP_IR: next_st.tap = tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_SH_IR:  next_st.tap = tms ? TAP_EX1_IR : TAP_SH_IR;
                TAP_EX1_IR: next_st.tap = tms ? TAP_UP_IR  : TAP_PA_IR;
                TAP_PA_IR:  next_st.tap = tms ? TAP_EX2_IR : TAP_PA_IR;
                TAP_EX2_IR: next_st.tap = tms ? TAP_UP_IR  : TAP_SH_IR;
                TAP_UP_IR:  next_st.tap = tms ? TAP_SEL_DR : TAP_RTI;
            endcase
        end
    end

    // test reset forces the controller home
    always_ff @(posedge clk) begin
        if (rst) begin
            st.tap <= TAP_TLR; // [R6]
        end else begin
            st <= next_st;
        end
    end

    assign state = st.tap;

    tap_reset_a: assert property (@(posedge clk) // [R6]
        rst |=> st.tap == TAP_TLR)
        else $error("controller not in reset state after test reset");

    tap_hold_a: assert property (@(posedge clk) disable iff (rst) // [R1]
        !step |=> $stable(st.tap))
        else $error("controller moved without a test clock rise");

    tap_leave_a: assert property (@(posedge clk) disable iff (rst) // [R18]
        step && st.tap == TAP_RTI && tms |=> st.tap == TAP_SEL_DR)
        else $error("controller missed run-idle to select-dr");

endmodule

// >>> sim/tsb_ctrl_model.sv
// Purpose: behavioural test controller that walks the scan port through its states
// Assumes: reference clock given only for pacing; link clock 8 reference cycles per period
// Notes:   test clock parks low between frames; data and test reset idle high, mode select low
`timescale 1ns/100ps
module tsb_ctrl_model (
    input  wire logic         clk,
    input  wire logic         tdo,
    input  wire logic         tdo_oe,
    output tsb_pkg::tsb_pins_t pins
);
    import tsb_pkg::*;

    // undriven mode select, data and test reset read high
    initial begin
        pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b1};
    end

    // one test clock period; lines change at the fall so they hold across the rise,
    // tdo is read late in the high phase because the port answers several cycles late
    task automatic tick(input logic m, input logic d, output logic q, output logic oe);
        pins.tms <= m;
        pins.tdi <= d;
        repeat (4) @(posedge clk);
        pins.tck <= 1'b1;
        repeat (3) @(posedge clk);
        q  = tdo_oe ? tdo : ~tdo; // a released pin has no pull, so it reads as junk
        oe = tdo_oe;
        @(posedge clk);
        pins.tck <= 1'b0;
    endtask

    // from idle into shift-ir or shift-dr
    task automatic enter(input bit ir);
        logic q;
        logic oe;
        tick(1'b1, 1'b1, q, oe);
        if (ir) begin
            tick(1'b1, 1'b1, q, oe);
        end
        tick(1'b0, 1'b1, q, oe);
        tick(1'b0, 1'b1, q, oe);
    endtask

    // full scan from idle back to idle; dout[i] is the bit seen while din[i] shifts in
    task automatic scan(input bit ir, input int n, input logic [175:0] din,
                        output logic [175:0] dout, output logic oe_all);
        logic q;
        logic oe;
        dout   = '0;
        oe_all = 1'b1;
        enter(ir);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q, oe);
            dout[i] = q;
            oe_all &= oe;
        end
        tick(1'b1, 1'b1, q, oe);
        tick(1'b0, 1'b1, q, oe);
    endtask

    // five mode-select highs reach reset, then one low to idle
    task automatic to_idle();
        logic q;
        logic oe;
        repeat (5) tick(1'b1, 1'b1, q, oe);
        tick(1'b0, 1'b1, q, oe);
    endtask

    // test reset level, held long enough to pass the synchronisers
    task automatic set_trst(input logic v);
        pins.trst_n <= v;
        repeat (6) @(posedge clk);
    endtask
endmodule

// >>> sim/tsb_scan_port_tb_top.sv
// Purpose: self-checking bench for the boundary-scan test port
// Assumes: controller model paces the link at 200 ns per test clock
// Notes:   expected chain mapping is recomputed here, not taken from the package
`timescale 1ns/100ps
module tsb_scan_port_tb_top;
    import tsb_pkg::*;

    logic               ref_clk;
    logic               rst;
    logic [BSR_LEN-1:0] core_capture;
    tsb_pins_t          pins;
    logic               tdo;
    logic               tdo_oe;
    tsb_drive_t         drive;
    int                 miscompares;
    int                 check_count;
    logic [175:0]       dout;
    logic [175:0]       din;
    logic               oe_all;

    tsb_scan_port u_tsb_scan_port (
        .REF_CLK      (ref_clk),
        .RST          (rst),
        .PINS         (pins),
        .CORE_CAPTURE (core_capture),
        .TDO          (tdo),
        .TDO_OE       (tdo_oe),
        .DRIVE        (drive)
    );

    tsb_ctrl_model u_tsb_ctrl_model (
        .clk    (ref_clk),
        .tdo    (tdo),
        .tdo_oe (tdo_oe),
        .pins   (pins)
    );

    // 40 MHz reference
    always #12.5 ref_clk = ~ref_clk;

    task automatic check(input logic [175:0] seen, input logic [175:0] exp_v, input string msg);
        check_count++;
        if (seen !== exp_v) begin
            miscompares++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // pad values expected from chain contents c
    function automatic tsb_drive_t drive_of(input logic [175:0] c, input logic ext);
        tsb_drive_t d;
        int         k;
        d.extest  = ext;
        d.ack_out = c[23];
        for (int b = 0; b < 16; b++) begin
            d.data_oe[b]  = c[24 + 3 * (15 - b)];
            d.data_out[b] = c[25 + 3 * (15 - b)];
        end
        for (int n = 0; n < 32; n++) begin
            k = 72 + 24 * ((31 - n) / 8) + 2 * ((31 - n) % 8);
            d.stream_oe[n]  = c[k];
            d.stream_out[n] = c[k + 1];
        end
        return d;
    endfunction

    task automatic load_ir(input logic [1:0] code);
        u_tsb_ctrl_model.scan(1'b1, 2, {174'h0, code}, dout, oe_all);
        check(dout[1:0], 2'h1, "instruction capture pattern");
        check(oe_all, 1'b1, "tdo enable while shifting");
        check(tdo_oe, 1'b0, "tdo released at idle");
        check(drive.extest, code == IR_EXTEST, "extest decode");
    endtask

    task automatic t_reset();
        check(tdo_oe, 1'b0, "tdo enable after reset");
        check(176'(drive), 176'h0, "pad drive after reset");
        u_tsb_ctrl_model.to_idle();
        $display("test reset done");
    endtask

    // every code: chain codes show captured pins, bypass codes a one-bit delay
    task automatic t_codes();
        for (int c = 0; c < 4; c++) begin
            load_ir(c[1:0]);
            u_tsb_ctrl_model.scan(1'b0, 3, 176'h5, dout, oe_all);
            check(dout[2:0], c[1] ? 3'h2 : core_capture[2:0], "data path");
        end
        $display("test codes done");
    endtask

    // full chain: order and length, then update into the pad latches
    task automatic t_chain();
        for (int j = 0; j < 176; j++) begin
            din[j] = (j % 3 == 0) ^ (j % 7 == 1);
        end
        load_ir(IR_SAMPLE);
        u_tsb_ctrl_model.scan(1'b0, 176, din, dout, oe_all);
        check(dout[167:0], core_capture, "captured chain order");
        check(dout[175:168], din[7:0], "chain length");
        check(176'(drive), 176'(drive_of(din >> 8, 1'b0)), "preloaded pad cells");
        load_ir(IR_EXTEST);
        check(176'(drive), 176'(drive_of(din >> 8, 1'b1)), "extest pad cells");
        $display("test chain done");
    endtask

    // test reset in mid-shift
    task automatic t_trst();
        logic q;
        logic oe;
        u_tsb_ctrl_model.enter(1'b0);
        repeat (4) u_tsb_ctrl_model.tick(1'b0, 1'b0, q, oe);
        check(oe, 1'b1, "tdo enable in shift-dr");
        u_tsb_ctrl_model.set_trst(1'b0);
        check(tdo_oe, 1'b0, "tdo released by test reset");
        check(176'(drive), 176'h0, "latches cleared by test reset");
        u_tsb_ctrl_model.set_trst(1'b1);
        u_tsb_ctrl_model.tick(1'b0, 1'b1, q, oe);
        $display("test trst done");
    endtask

    // mode-select walk to reset restores bypass
    task automatic t_tms_reset();
        load_ir(IR_EXTEST);
        u_tsb_ctrl_model.to_idle();
        check(drive.extest, 1'b0, "reset walk clears extest");
        $display("test tms reset done");
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // whole run is near 60 us; a hang is cut well after that
    initial begin
        #500000;
        miscompares++;
        end_of_test();
    end

    initial begin
        ref_clk     = 1'b0;
        rst         = 1'b1;
        miscompares = 0;
        check_count = 0;
        din         = '0;
        for (int i = 0; i < BSR_LEN; i++) begin
            core_capture[i] <= (i % 5 == 2) ^ (i % 11 == 0);
        end
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_codes();
        t_chain();
        t_trst();
        t_tms_reset();
        end_of_test();
    end
endmodule
